// ===== logic/bfp_top.sv
// two-way queue port controller: buffer module and top
// assumes port clocks arrive as plain inputs synchronous to clock_i
`timescale 1ns/1ps
`include "bfp_consts.svh"

////////////////////////////////////////////////////////////////////////////////
module bfp_fifo #(
   parameter int WIDTH = `BFP_DATA_W,
   parameter int DEPTH = `BFP_BUF_DEPTH,
   parameter int CNT_W = $clog2(DEPTH + 1)
) (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic wr_valid_i,
   output logic wr_ready_o,
   input wire logic [WIDTH-1:0] wr_data_i,
   output logic rd_valid_o,
   input wire logic rd_ready_i,
   output logic [WIDTH-1:0] rd_data_o,
   output logic [CNT_W-1:0] count_o
);
   localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [WIDTH-1:0] mem [DEPTH];
   logic [PTR_W-1:0] wptr_q;
   logic [PTR_W-1:0] rptr_q;
   logic [CNT_W-1:0] cnt_q;
   logic push;
   logic pop;

   assign wr_ready_o = (cnt_q != CNT_W'(DEPTH));
   assign rd_valid_o = (cnt_q != '0);
   assign push = wr_valid_i & wr_ready_o & ce_i;
   assign pop = rd_ready_i & rd_valid_o & ce_i;
   assign rd_data_o = mem[rptr_q];
   assign count_o = cnt_q;

   always_ff @(posedge clock_i) begin
      if (push) begin
         mem[wptr_q] <= wr_data_i;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         wptr_q <= '0;
         rptr_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wptr_q <= (wptr_q == PTR_W'(DEPTH - 1)) ? '0 : wptr_q + 1'b1;
         end
         if (pop) begin
            rptr_q <= (rptr_q == PTR_W'(DEPTH - 1)) ? '0 : rptr_q + 1'b1;
         end
         cnt_q <= cnt_q + CNT_W'(push) - CNT_W'(pop);
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - right port pieces use high lanes when lane select low, low lanes when high
// - each port transfers only on its own clock's rising edge; left output register loads every clock_i cycle with ce_i high
// - left flags change only on left clock rising edges
// - right width changes take effect on right clock edges with right flags
// - left transfers need select low; left outputs released while select high
// - right transfers need select low; right outputs released while select high
// - a port's enable must be high for its edge to transfer anything
// - left empty flag low blocks reads from the reverse queue
// - left empty flag low at reset, high on second left edge after a write
// - right empty flag low blocks reads from the forward queue
// - right empty flag low at reset, high on second right edge after a write
// - left full flag low blocks left writes into the forward queue
// - left full flag low at reset, high on second left edge after reset
// - right full flag low blocks right writes into the reverse queue
// - right full flag low at reset, high on second right edge after reset
// - offset selects latched at reset release choose one of four offsets
// - left mailbox select picks mailbox access and the left output source
// - left mailbox write drops forward mail flag; more writes ignored while low
// - forward mail flag rises on right mailbox read; high after reset
// - right mailbox write drops reverse mail flag; more writes ignored while low
// - reverse mail flag rises on left mailbox read; high after reset
// - write/read select high writes, low reads; outputs released while high
// - left almost-empty low while reverse queue count is at most the offset
// - right width and lane selects sampled on one edge, applied on the next
module bfp_top
   import bfp_pkg::*;
#(
   parameter int DATA_W = `BFP_DATA_W,
   parameter int QUEUE_DEPTH = `BFP_QUEUE_DEPTH
) (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic offset_select_lo_i,
   input wire logic offset_select_hi_i,
   input wire logic left_port_clock_i,
   input wire logic left_port_select_n_i,
   input wire logic left_transfer_enable_i,
   input wire logic left_write_not_read_i,
   input wire logic left_mailbox_select_i,
   input wire logic [DATA_W-1:0] left_data_i,
   output logic [DATA_W-1:0] left_data_o,
   output logic left_data_oe_o,
   output logic left_empty_n_o,
   output logic left_full_n_o,
   output logic left_almost_empty_n_o,
   output logic left_almost_full_n_o,
   input wire logic right_port_clock_i,
   input wire logic right_port_select_n_i,
   input wire logic right_transfer_enable_i,
   input wire logic right_write_not_read_i,
   input wire logic width_select_lo_i,
   input wire logic width_select_hi_i,
   input wire logic lane_order_select_i,
   input wire logic [DATA_W-1:0] right_data_i,
   output logic [DATA_W-1:0] right_data_o,
   output logic right_data_oe_o,
   output logic right_empty_n_o,
   output logic right_full_n_o,
   output logic right_almost_empty_n_o,
   output logic right_almost_full_n_o,
   output logic fwd_mail_flag_n_o,
   output logic rev_mail_flag_n_o
);
   localparam int CW = `BFP_CNT_W;

   function automatic logic [2:0] piece_count(bfp_width_t w);
      unique case (w)
         bfp_byte: piece_count = 3'd4;
         bfp_word: piece_count = 3'd2;
         bfp_long, bfp_mail: piece_count = 3'd1;
      endcase
   endfunction

   function automatic logic [35:0] piece_mask(bfp_width_t w);
      unique case (w)
         bfp_byte: piece_mask = `BFP_BYTE_MASK;
         bfp_word: piece_mask = `BFP_WORD_MASK;
         bfp_long, bfp_mail: piece_mask = `BFP_LONG_MASK;
      endcase
   endfunction

   function automatic logic [5:0] piece_size(bfp_width_t w);
      unique case (w)
         bfp_byte: piece_size = `BFP_BYTE_W;
         bfp_word: piece_size = `BFP_WORD_W;
         bfp_long, bfp_mail: piece_size = 6'h00;
      endcase
   endfunction

   // bit position of a piece inside the long word; big order fills from the top
   function automatic logic [5:0] piece_shift(bfp_width_t w, logic lane, logic [1:0] idx);
      logic [2:0] n;
      n = piece_count(w);
      if (lane) begin
         piece_shift = 6'(idx * piece_size(w));
      end else begin
         piece_shift = 6'((n - 3'd1 - {1'b0, idx}) * piece_size(w));
      end
   endfunction

   // bus lane position: high lanes with lane select low
   function automatic logic [5:0] bus_shift(bfp_width_t w, logic lane);
      if (lane || piece_size(w) == 6'h00) begin
         bus_shift = 6'h00;
      end else begin
         bus_shift = 6'(DATA_W) - piece_size(w);
      end
   endfunction

   function automatic logic [CW-1:0] offset_value(logic [1:0] sel);
      unique case (sel)
         2'd0: offset_value = `BFP_OFFSET_0;
         2'd1: offset_value = `BFP_OFFSET_1;
         2'd2: offset_value = `BFP_OFFSET_2;
         2'd3: offset_value = `BFP_OFFSET_3;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // edges and qualified actions
   logic left_clk_q;
   logic right_clk_q;
   logic l_edge;
   logic r_edge;
   logic l_qual;
   logic r_qual;

   assign l_edge = ce_i & left_port_clock_i & ~left_clk_q;
   assign r_edge = ce_i & right_port_clock_i & ~right_clk_q;
   assign l_qual = l_edge & ~left_port_select_n_i & left_transfer_enable_i;
   assign r_qual = r_edge & ~right_port_select_n_i & right_transfer_enable_i;

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         left_clk_q <= 1'b0;
         right_clk_q <= 1'b0;
      end else if (ce_i) begin
         left_clk_q <= left_port_clock_i;
         right_clk_q <= right_port_clock_i;
      end
   end

   // offsets caught on the first cycle after reset release
   logic off_pend_q;
   logic [1:0] off_sel_q;
   logic [CW-1:0] offset;
   assign offset = offset_value(off_sel_q);

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         off_pend_q <= 1'b1;
         off_sel_q <= 2'd0;
      end else if (ce_i && off_pend_q) begin
         off_pend_q <= 1'b0;
         off_sel_q <= {offset_select_hi_i, offset_select_lo_i};
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // queues
   logic fwd_wr_ready;
   logic fwd_rd_valid;
   logic [DATA_W-1:0] fwd_rd_data;
   logic [CW-1:0] fwd_cnt;
   logic rev_wr_ready;
   logic rev_rd_valid;
   logic [DATA_W-1:0] rev_rd_data;
   logic [CW-1:0] rev_cnt;
   logic l_push;
   logic l_pop;
   logic r_push;
   logic r_pop;
   logic [DATA_W-1:0] r_asm_d;

   bfp_fifo #(.WIDTH(DATA_W), .DEPTH(QUEUE_DEPTH), .CNT_W(CW)) u_fwd_queue (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_i),
      .wr_valid_i(l_push),
      .wr_ready_o(fwd_wr_ready),
      .wr_data_i(left_data_i),
      .rd_valid_o(fwd_rd_valid),
      .rd_ready_i(r_pop),
      .rd_data_o(fwd_rd_data),
      .count_o(fwd_cnt)
   );

   bfp_fifo #(.WIDTH(DATA_W), .DEPTH(QUEUE_DEPTH), .CNT_W(CW)) u_rev_queue (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_i),
      .wr_valid_i(r_push),
      .wr_ready_o(rev_wr_ready),
      .wr_data_i(r_asm_d),
      .rd_valid_o(rev_rd_valid),
      .rd_ready_i(l_pop),
      .rd_data_o(rev_rd_data),
      .count_o(rev_cnt)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // left port
   logic left_full_n_q;
   logic left_full_s_q;
   logic left_empty_n_q;
   logic left_empty_s_q;
   logic left_ae_n_q;
   logic left_af_n_q;
   logic fwd_flag_q;
   logic rev_flag_q;
   logic [DATA_W-1:0] fwd_mailbox_q;
   logic [DATA_W-1:0] rev_mailbox_q;
   logic [DATA_W-1:0] left_word_q;
   logic [DATA_W-1:0] left_data_q;
   logic l_mb_wr;
   logic l_mb_rd;
   logic [CW-1:0] fwd_after_l;
   logic [CW-1:0] rev_after_l;

   assign l_push = l_qual & left_write_not_read_i & ~left_mailbox_select_i
      & left_full_n_q & fwd_wr_ready;
   assign l_pop = l_qual & ~left_write_not_read_i & ~left_mailbox_select_i
      & left_empty_n_q & rev_rd_valid;
   assign l_mb_wr = l_qual & left_write_not_read_i & left_mailbox_select_i & fwd_flag_q;
   assign l_mb_rd = l_qual & ~left_write_not_read_i & left_mailbox_select_i;
   assign fwd_after_l = fwd_cnt + CW'(l_push);
   assign rev_after_l = rev_cnt - CW'(l_pop);

   // two-stage flags: the reading side drops at once, rises one edge late
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         left_full_s_q <= 1'b0;
         left_full_n_q <= 1'b0;
         left_empty_s_q <= 1'b0;
         left_empty_n_q <= 1'b0;
         left_ae_n_q <= 1'b0;
         left_af_n_q <= 1'b1;
      end else if (l_edge) begin
         left_full_s_q <= (fwd_after_l != CW'(QUEUE_DEPTH));
         left_full_n_q <= left_full_s_q & (fwd_after_l != CW'(QUEUE_DEPTH));
         left_empty_s_q <= (rev_after_l != '0);
         left_empty_n_q <= left_empty_s_q & (rev_after_l != '0);
         left_ae_n_q <= (rev_after_l > offset);
         left_af_n_q <= ((CW'(QUEUE_DEPTH) - fwd_after_l) > offset);
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         fwd_mailbox_q <= '0;
      end else if (l_mb_wr) begin
         fwd_mailbox_q <= left_data_i;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         left_word_q <= '0;
         left_data_q <= '0;
      end else if (ce_i) begin
         if (l_pop) begin
            left_word_q <= rev_rd_data;
         end
         left_data_q <= left_mailbox_select_i ? rev_mailbox_q : left_word_q;
      end
   end

   assign left_data_o = left_data_q;
   assign left_data_oe_o = ~left_port_select_n_i & ~left_write_not_read_i;
   assign left_empty_n_o = left_empty_n_q;
   assign left_full_n_o = left_full_n_q;
   assign left_almost_empty_n_o = left_ae_n_q;
   assign left_almost_full_n_o = left_af_n_q;

   ////////////////////////////////////////////////////////////////////////////////
   // right port
   bfp_width_t r_smp_q;
   bfp_width_t r_act_q;
   logic r_smp_lane_q;
   logic r_lane_q;
   logic [1:0] r_part_q;
   logic [DATA_W-1:0] r_asm_q;
   logic [DATA_W-1:0] r_hold_q;
   logic [DATA_W-1:0] r_data_q;
   logic right_full_n_q;
   logic right_full_s_q;
   logic right_empty_n_q;
   logic right_empty_s_q;
   logic right_ae_n_q;
   logic right_af_n_q;
   logic r_mail;
   logic r_last;
   logic r_wr_piece;
   logic r_rd_piece;
   logic r_mb_wr;
   logic r_mb_rd;
   logic [5:0] r_ps;
   logic [5:0] r_bs;
   logic [DATA_W-1:0] r_mask;
   logic [DATA_W-1:0] r_in_piece;
   logic [DATA_W-1:0] r_src_word;
   logic [CW-1:0] fwd_after_r;
   logic [CW-1:0] rev_after_r;

   assign r_mail = (r_act_q == bfp_mail);
   assign r_last = ({1'b0, r_part_q} == piece_count(r_act_q) - 3'd1);
   assign r_ps = piece_shift(r_act_q, r_lane_q, r_part_q);
   assign r_bs = bus_shift(r_act_q, r_lane_q);
   assign r_mask = piece_mask(r_act_q);
   assign r_in_piece = (right_data_i >> r_bs) & r_mask;
   assign r_asm_d = (r_asm_q & ~(r_mask << r_ps)) | (r_in_piece << r_ps);
   assign r_src_word = (r_part_q == 2'd0) ? fwd_rd_data : r_hold_q;

   assign r_wr_piece = r_qual & right_write_not_read_i & ~r_mail & right_full_n_q;
   assign r_push = r_wr_piece & r_last & rev_wr_ready;
   assign r_rd_piece = r_qual & ~right_write_not_read_i & ~r_mail
      & ((r_part_q != 2'd0) | (right_empty_n_q & fwd_rd_valid));
   assign r_pop = r_rd_piece & (r_part_q == 2'd0);
   assign r_mb_wr = r_qual & right_write_not_read_i & r_mail & rev_flag_q;
   assign r_mb_rd = r_qual & ~right_write_not_read_i & r_mail;
   assign fwd_after_r = fwd_cnt - CW'(r_pop);
   assign rev_after_r = rev_cnt + CW'(r_push);

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         r_smp_q <= bfp_long;
         r_act_q <= bfp_long;
         r_smp_lane_q <= 1'b0;
         r_lane_q <= 1'b0;
      end else if (r_edge) begin
         r_smp_q <= bfp_width_t'({width_select_hi_i, width_select_lo_i});
         r_smp_lane_q <= lane_order_select_i;
         r_act_q <= r_smp_q;
         r_lane_q <= r_smp_lane_q;
      end
   end

   // a width change mid-word abandons the partial word
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         r_part_q <= 2'd0;
         r_asm_q <= '0;
         r_hold_q <= '0;
      end else if (r_edge) begin
         if (r_act_q != r_smp_q || r_lane_q != r_smp_lane_q) begin
            r_part_q <= 2'd0;
         end else if ((r_wr_piece && (!r_last || rev_wr_ready)) || r_rd_piece) begin
            r_part_q <= r_last ? 2'd0 : r_part_q + 2'd1;
         end
         if (r_wr_piece) begin
            r_asm_q <= r_asm_d;
         end
         if (r_pop) begin
            r_hold_q <= fwd_rd_data;
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         r_data_q <= '0;
      end else if (r_mb_rd) begin
         r_data_q <= fwd_mailbox_q;
      end else if (r_rd_piece) begin
         r_data_q <= ((r_src_word >> r_ps) & r_mask) << r_bs;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         rev_mailbox_q <= '0;
      end else if (r_mb_wr) begin
         rev_mailbox_q <= right_data_i;
      end
   end

   // a write in the same cycle as the far read wins
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         fwd_flag_q <= 1'b1;
         rev_flag_q <= 1'b1;
      end else begin
         if (l_mb_wr) begin
            fwd_flag_q <= 1'b0;
         end else if (r_mb_rd) begin
            fwd_flag_q <= 1'b1;
         end
         if (r_mb_wr) begin
            rev_flag_q <= 1'b0;
         end else if (l_mb_rd) begin
            rev_flag_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         right_full_s_q <= 1'b0;
         right_full_n_q <= 1'b0;
         right_empty_s_q <= 1'b0;
         right_empty_n_q <= 1'b0;
         right_ae_n_q <= 1'b0;
         right_af_n_q <= 1'b1;
      end else if (r_edge) begin
         right_full_s_q <= (rev_after_r != CW'(QUEUE_DEPTH));
         right_full_n_q <= right_full_s_q & (rev_after_r != CW'(QUEUE_DEPTH));
         right_empty_s_q <= (fwd_after_r != '0);
         right_empty_n_q <= right_empty_s_q & (fwd_after_r != '0);
         right_ae_n_q <= (fwd_after_r > offset);
         right_af_n_q <= ((CW'(QUEUE_DEPTH) - rev_after_r) > offset);
      end
   end

   assign right_data_o = r_data_q;
   assign right_data_oe_o = ~right_port_select_n_i & ~right_write_not_read_i;
   assign right_empty_n_o = right_empty_n_q;
   assign right_full_n_o = right_full_n_q;
   assign right_almost_empty_n_o = right_ae_n_q;
   assign right_almost_full_n_o = right_af_n_q;
   assign fwd_mail_flag_n_o = fwd_flag_q;
   assign rev_mail_flag_n_o = rev_flag_q;
endmodule

// ===== logic/bfp_consts.svh
// constants for the two-way queue port controller
// assumes inclusion by bare name from the package and the top file
`ifndef BFP_CONSTS_SVH
`define BFP_CONSTS_SVH
`define BFP_DATA_W 36
`define BFP_QUEUE_DEPTH 64
`define BFP_BUF_DEPTH 32
`define BFP_CNT_W 7
`define BFP_OFFSET_0 7'h10
`define BFP_OFFSET_1 7'h0c
`define BFP_OFFSET_2 7'h08
`define BFP_OFFSET_3 7'h04
`define BFP_BYTE_MASK 36'h0000001ff
`define BFP_WORD_MASK 36'h00003ffff
`define BFP_LONG_MASK 36'hfffffffff
`define BFP_BYTE_W 6'h09
`define BFP_WORD_W 6'h12
`endif

// ===== logic/bfp_pkg.sv
// types shared by the port controller
// assumes bfp_consts.svh is on the include path
`include "bfp_consts.svh"
package bfp_pkg;
   // order follows {width_select_hi, width_select_lo}
   typedef enum logic [1:0] {
      bfp_long,
      bfp_byte,
      bfp_word,
      bfp_mail
   } bfp_width_t;
endpackage

// ===== dv/bfp_top_asserts.sv
// port-level checker for the two-way queue port controller
// assumes port clocks are sampled on clock_i and ce_i is held high
`timescale 1ns/1ps
module bfp_top_asserts #(
   parameter int QUEUE_DEPTH = 64
) (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic left_port_clock_i,
   input wire logic left_port_select_n_i,
   input wire logic left_transfer_enable_i,
   input wire logic left_write_not_read_i,
   input wire logic left_mailbox_select_i,
   input wire logic left_data_oe_o,
   input wire logic left_empty_n_o,
   input wire logic left_full_n_o,
   input wire logic left_almost_empty_n_o,
   input wire logic left_almost_full_n_o,
   input wire logic right_port_clock_i,
   input wire logic right_port_select_n_i,
   input wire logic right_transfer_enable_i,
   input wire logic right_write_not_read_i,
   input wire logic width_select_lo_i,
   input wire logic width_select_hi_i,
   input wire logic right_data_oe_o,
   input wire logic right_empty_n_o,
   input wire logic right_full_n_o,
   input wire logic right_almost_empty_n_o,
   input wire logic right_almost_full_n_o,
   input wire logic fwd_mail_flag_n_o,
   input wire logic rev_mail_flag_n_o
);
   logic lclk_q, rclk_q, l_edge, r_edge, l_act, r_act, r_mbox;
   logic [2:0] mb_cnt;
   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clock_i) begin
      lclk_q <= left_port_clock_i;
      rclk_q <= right_port_clock_i;
   end
   // width pins act two edges late, so only trust a long-held mailbox select
   always_ff @(posedge clock_i) begin
      if (!(width_select_hi_i && width_select_lo_i)) mb_cnt <= 3'h0;
      else if (mb_cnt != 3'h7) mb_cnt <= mb_cnt + 3'h1;
   end
   assign l_edge = ce_i & left_port_clock_i & ~lclk_q;
   assign r_edge = ce_i & right_port_clock_i & ~rclk_q;
   assign l_act = l_edge & ~left_port_select_n_i & left_transfer_enable_i;
   assign r_act = r_edge & ~right_port_select_n_i & right_transfer_enable_i;
   assign r_mbox = (mb_cnt == 3'h7);
   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   a_left_flag_sync:
      assert property ($changed({left_empty_n_o, left_full_n_o, left_almost_empty_n_o,
         left_almost_full_n_o}) |-> $past(l_edge)) else $error("left flag off left edge");
   a_right_flag_sync:
      assert property ($changed({right_empty_n_o, right_full_n_o, right_almost_empty_n_o,
         right_almost_full_n_o}) |-> $past(r_edge)) else $error("right flag off right edge");
   a_left_oe_gate:
      assert property (left_data_oe_o |-> !left_port_select_n_i && !left_write_not_read_i)
      else $error("left data driven while deselected or writing");
   a_right_oe_gate:
      assert property (right_data_oe_o |-> !right_port_select_n_i && !right_write_not_read_i)
      else $error("right data driven while deselected or writing");
   a_fwd_mail_set:
      assert property (l_act && left_write_not_read_i && left_mailbox_select_i
         |=> !fwd_mail_flag_n_o) else $error("forward mail flag not low after write");
   a_rev_mail_set:
      assert property (r_act && right_write_not_read_i && r_mbox |=> !rev_mail_flag_n_o)
      else $error("reverse mail flag not low after write");
   a_fwd_mail_clear:
      assert property (r_act && !right_write_not_read_i && r_mbox
         && !(l_act && left_write_not_read_i) |=> fwd_mail_flag_n_o)
      else $error("forward mail flag not high after right read");
   a_rev_mail_clear:
      assert property (l_act && !left_write_not_read_i && left_mailbox_select_i
         && !(r_act && right_write_not_read_i) |=> rev_mail_flag_n_o)
      else $error("reverse mail flag not high after left read");
   a_reset_flag_vals:
      assert property ($rose(rst_n_i) |-> !left_empty_n_o && !left_full_n_o
         && !right_empty_n_o && !right_full_n_o && fwd_mail_flag_n_o && rev_mail_flag_n_o)
      else $error("flag values wrong at reset release");
   a_full_after_reset:
      assert property ($rose(rst_n_i) |-> !left_full_n_o [*2] ##[1:6] left_full_n_o)
      else $error("left full flag timing wrong after reset");
   c_fwd_mail: cover property (!fwd_mail_flag_n_o ##1 fwd_mail_flag_n_o);
   c_left_full: cover property ($fell(left_full_n_o));
   c_right_empty: cover property ($rose(right_empty_n_o));
endmodule

bind bfp_top bfp_top_asserts #(.QUEUE_DEPTH(QUEUE_DEPTH)) u_chk (.*);

// ===== dv/bfp_port_clk_model.sv
// far-side port clock source for the port controller bench
// assumes clock_i from the bench; both port clocks run free, also in reset
`timescale 1ns/1ps
module bfp_port_clk_model (
   input wire logic clock_i,
   output logic left_port_clock_o,
   output logic right_port_clock_o
);
   // opposite phases keep the two ports' edges apart in the sampled domain
   initial begin
      left_port_clock_o = 1'b0;
      right_port_clock_o = 1'b1;
   end
   always @(posedge clock_i) begin
      left_port_clock_o <= ~left_port_clock_o;
      right_port_clock_o <= ~right_port_clock_o;
   end
endmodule

// ===== dv/bfp_top_tb.sv
// self-checking bench for the two-way queue port controller
// assumes the design under logic/ and the port clock model
`timescale 1ns/1ps
`include "bfp_consts.svh"
module bfp_top_tb;
   logic clock_i, rst_n_i, osel_lo, osel_hi, lclk, rclk;
   logic lsn, len, lwr, lmb, rsn, ren, rwr, rlane;
   logic loe, roe, lemp, lful, lae, laf, remp, rful, rae, raf, fmf, rmf;
   logic [1:0] rsz;
   logic [35:0] ldi, rdi, ldo, rdo, d, pc;
   logic [35:0] fq[$], rq[$];
   int errors, checked, osel, n, s;
   int off[4];
   ////////////////////////////////////////////////////////////////////////////
   bfp_port_clk_model pm (.clock_i(clock_i), .left_port_clock_o(lclk),
      .right_port_clock_o(rclk));
   bfp_top dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(1'b1),
      .offset_select_lo_i(osel_lo), .offset_select_hi_i(osel_hi),
      .left_port_clock_i(lclk), .left_port_select_n_i(lsn), .left_transfer_enable_i(len),
      .left_write_not_read_i(lwr), .left_mailbox_select_i(lmb), .left_data_i(ldi),
      .left_data_o(ldo), .left_data_oe_o(loe), .left_empty_n_o(lemp), .left_full_n_o(lful),
      .left_almost_empty_n_o(lae), .left_almost_full_n_o(laf),
      .right_port_clock_i(rclk), .right_port_select_n_i(rsn), .right_transfer_enable_i(ren),
      .right_write_not_read_i(rwr), .width_select_lo_i(rsz[0]), .width_select_hi_i(rsz[1]),
      .lane_order_select_i(rlane), .right_data_i(rdi), .right_data_o(rdo),
      .right_data_oe_o(roe), .right_empty_n_o(remp), .right_full_n_o(rful),
      .right_almost_empty_n_o(rae), .right_almost_full_n_o(raf),
      .fwd_mail_flag_n_o(fmf), .rev_mail_flag_n_o(rmf));
   initial begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [35:0] got, input logic [35:0] exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   function automatic logic [35:0] rnd();
      logic [63:0] t;
      t = {$urandom(), $urandom()};
      return t[35:0];
   endfunction
   task automatic settle(input int c);
      repeat (c) @(posedge clock_i);
      #1;
   endtask
   // select is dropped after the edge so a held request never repeats
   task automatic lop(input logic w, input logic m, input logic [35:0] dv,
      input logic sn = 1'b0, input logic en = 1'b1);
      lsn = sn;
      len = en;
      lwr = w;
      lmb = m;
      ldi = dv;
      do @(posedge clock_i); while (lclk !== 1'b1);
      #1 len = 1'b0;
      lsn = 1'b1;
      settle(1);
   endtask
   task automatic rop(input logic w, input logic [35:0] dv);
      rsn = 1'b0;
      ren = 1'b1;
      rwr = w;
      rdi = dv;
      do @(posedge clock_i); while (rclk !== 1'b1);
      #1 ren = 1'b0;
      rsn = 1'b1;
      settle(1);
   endtask
   task automatic close_out();
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      #200000;
      errors++;
      close_out();
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      rst_n_i = 1'b0;
      {lsn, len, lwr, lmb, ldi} = {4'h8, 36'h0};
      {rsn, ren, rwr, rlane, rsz, rdi} = {6'h20, 36'h0};
      errors = 0;
      checked = 0;
      off = '{`BFP_OFFSET_0, `BFP_OFFSET_1, `BFP_OFFSET_2, `BFP_OFFSET_3};
      void'($urandom(10));
      osel = $urandom % 4;
      {osel_hi, osel_lo} = osel[1:0];
      repeat (8) @(posedge clock_i);
      #1 rst_n_i = 1'b1;
      chk({lemp, lful, remp, rful, fmf, rmf, laf, raf, rae}, 9'h01e);
      settle(8);
      chk({lful, rful}, 2'h3);
      $display("test reset done");
      lop(1'b1, 1'b0, rnd(), 1'b1);
      lop(1'b1, 1'b0, rnd(), 1'b0, 1'b0);
      settle(8);
      chk(remp, 1'b0);
      for (int i = 0; i < `BFP_QUEUE_DEPTH; i++) begin
         d = rnd();
         fq.push_back(d);
         lop(1'b1, 1'b0, d);
      end
      settle(8);
      chk(lful, 1'b0);
      lop(1'b1, 1'b0, rnd());
      for (int i = 0; i < `BFP_QUEUE_DEPTH; i++) begin
         rop(1'b0, '0);
         chk(rdo, fq.pop_front());
      end
      settle(8);
      chk(remp, 1'b0);
      rop(1'b0, '0);
      chk(rdo, d);
      $display("test fill and drain done");
      repeat (off[osel] + 1) begin
         if (rq.size() == off[osel]) begin
            settle(8);
            chk({lae, lemp}, 2'h1);
         end
         d = rnd();
         rq.push_back(d);
         rop(1'b1, d);
      end
      settle(8);
      chk({lae, lemp}, 2'h3);
      while (rq.size() > 0) begin
         lop(1'b0, 1'b0, '0);
         settle(1);
         chk(ldo, rq.pop_front());
      end
      settle(8);
      lop(1'b0, 1'b0, '0);
      settle(1);
      chk(ldo, d);
      $display("test reverse and offsets done");
      d = rnd();
      lop(1'b1, 1'b1, d);
      lop(1'b1, 1'b1, rnd());
      rsz = 2'h3;
      settle(8);
      chk(fmf, 1'b0);
      rop(1'b0, '0);
      chk(rdo, d);
      settle(4);
      chk(fmf, 1'b1);
      d = rnd();
      rop(1'b1, d);
      rop(1'b1, rnd());
      settle(4);
      chk(rmf, 1'b0);
      lop(1'b0, 1'b1, '0);
      settle(1);
      chk(ldo, d);
      settle(4);
      chk(rmf, 1'b1);
      $display("test mailboxes done");
      for (int k = 0; k < 4; k++) begin
         d = rnd();
         lop(1'b1, 1'b0, d);
         rsz = k[1] ? 2'h2 : 2'h1;
         rlane = k[0];
         settle(8);
         n = (rsz == 2'h1) ? 4 : 2;
         s = 36 / n;
         for (int p = 0; p < n; p++) begin
            rop(1'b0, '0);
            pc = (d >> (s * (rlane ? p : n - 1 - p))) & ((36'h1 << s) - 36'h1);
            chk(rdo, rlane ? pc : pc << (36 - s));
         end
      end
      repeat (2 * `BFP_QUEUE_DEPTH + 2) rop(1'b1, rnd());
      settle(8);
      chk(rful, 1'b0);
      $display("test lanes done");
      close_out();
   end
endmodule
